/* logic/sensor_control_pkg.sv */
// Constants for the sensor control register bank
package sensor_control_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CONTROL_TWO     = 8'h11;
  localparam logic [7:0] OFF_IRQ_PIN_CONTROL = 8'h12;
  localparam logic [7:0] OFF_QUEUE_CONFIG    = 8'h14;
  localparam logic [7:0] OFF_REF_LOW         = 8'h15;
  localparam logic [7:0] OFF_REF_MID         = 8'h16;
  localparam logic [7:0] OFF_REF_HIGH        = 8'h17;
  localparam logic [7:0] OFF_OFFSET_LOW      = 8'h18;
  localparam logic [7:0] OFF_OFFSET_HIGH     = 8'h19;
  localparam logic [7:0] OFF_LOW_CURRENT     = 8'h1A;
  // ----------------------------------------
  // Field positions in control_two
  // ----------------------------------------
  localparam int BIT_TRIM_RELOAD  = 7;
  localparam int BIT_QUEUE_EN     = 6;
  localparam int BIT_WM_STOP      = 5;
  localparam int BIT_AUTOINC      = 4;
  localparam int BIT_TWO_WIRE_DIS = 3;
  localparam int BIT_SOFT_RESET   = 2;
  localparam int BIT_SINGLE_CONV  = 0;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CONTROL_TWO = 8'h10;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [2:0] RATE_POWER_DOWN = 3'h0;
  // ----------------------------------------
  // Interrupt source codes
  // ----------------------------------------
  localparam logic [1:0] SRC_DATA     = 2'h0;
  localparam logic [1:0] SRC_HIGH     = 2'h1;
  localparam logic [1:0] SRC_LOW      = 2'h2;
  localparam logic [1:0] SRC_LOW_HIGH = 2'h3;
  // ----------------------------------------
  // Queue modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    QM_BYPASS = 3'h0, QM_FIFO = 3'h1, QM_STREAM = 3'h2, QM_STREAM_TO_FIFO = 3'h3,
    QM_BYPASS_TO_STREAM = 3'h4, QM_RESERVED = 3'h5, QM_DYNAMIC = 3'h6, QM_BYPASS_TO_FIFO = 3'h7
  } queue_mode_t;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int TRIM_COPY_CYCLES = 16;  // Cycles of the trim copy walk
  localparam int CONV_CYCLES      = 32;  // Cycles of one measurement
endpackage

/* logic/sensor_control_register_bank.sv */
// Control and configuration register bank of a barometric sensor
`timescale 1ns/1ns
module sensor_control_register_bank
  import sensor_control_pkg::*;
#(
  parameter int TRIM_WORDS = 16  // Trim words copied from the store
) (
  input  wire logic                           I_CLOCK,
  input  wire logic                           I_RST,
  input  wire logic                           i_wr,          // Register write strobe
  input  wire logic                           i_rd,          // Register read strobe
  input  wire logic                           i_first,       // First byte of an access
  input  wire logic [7:0]                     i_addr,        // Start address of access
  input  wire logic [7:0]                     i_wdata,       // Write byte
  input  wire logic [2:0]                     i_rate_field,  // Output data rate setting
  input  wire logic                           i_rate_tick,   // One pulse per rate cycle
  input  wire logic [7:0]                     i_trim_data,   // Trim store read data
  input  wire logic                           i_queue_full,
  input  wire logic                           i_queue_watermark,
  input  wire logic                           i_queue_overrun,
  input  wire logic                           i_data_ready,
  input  wire logic                           i_pressure_high,
  input  wire logic                           i_pressure_low,
  output logic      [7:0]                     O_RDATA,
  output logic      [7:0]                     O_TRIM_ADDR,
  output logic                                O_TRIM_WE,     // Trim register load strobe
  output logic                                O_CONV_START,  // Single measurement pulse
  output logic                                O_RATE_RESET,  // Soft reset pulse to rate register
  output logic                                O_QUEUE_ENABLE,
  output logic                                O_WATERMARK_STOP,
  output logic      [2:0]                     O_QUEUE_MODE,
  output logic      [4:0]                     O_WATERMARK_LEVEL,
  output logic                                O_TWO_WIRE_DISABLE,
  output logic      [23:0]                    O_REFERENCE,
  output logic      [15:0]                    O_OFFSET,
  output logic                                O_LOW_CURRENT,
  output logic                                O_INT_OUT,     // Interrupt pin level
  output logic                                O_INT_OE       // Interrupt pin enable
);
  import sensor_control_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {TR_IDLE = 2'b00, TR_WAIT = 2'b01, TR_COPY = 2'b11} trim_state_t;

  typedef struct packed {
    trim_state_t trim;       // Trim copy sequencer
    logic [7:0]  trim_cnt;   // Word index of the copy
    logic [7:0]  trim_addr;  // Index of the word being loaded
    logic [7:0]  addr;       // Current access address
    logic [7:0]  ctrl2;      // Control two image
    logic [7:0]  irqc;       // Interrupt pin control
    logic [7:0]  qcfg;       // Queue configuration
    logic [23:0] refp;       // Reference pressure
    logic [15:0] offs;       // Pressure offset
    logic        lc;         // Low current enable
    logic [7:0]  conv_cnt;   // Single conversion timer
    logic [7:0]  rdata;
    logic        trim_we;
    logic        conv_start;
    logic        rate_reset;
    logic        int_out;
    logic        int_oe;
  } state_t;

  state_t cur;       // Registered state
  state_t nxt;       // Next value
  logic   access;    // Any byte access this cycle
  logic [7:0] a;     // Effective address of this byte
  logic   data_sig;  // Data signal for source code zero
  logic   raw_irq;   // Selected event before polarity

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt = cur;
    nxt.trim_we    = 1'b0;
    nxt.conv_start = 1'b0;
    nxt.rate_reset = 1'b0;
    access = i_wr | i_rd;
    // Byte address: start address on the first byte, else the held pointer
    a = i_first ? i_addr : cur.addr;
    if (access) begin
      // Pointer steps only with auto-increment set
      nxt.addr = cur.ctrl2[BIT_AUTOINC] ? a + 8'h01 : a;
    end
    // Register writes
    if (i_wr) begin
      unique case (a)
        OFF_CONTROL_TWO: begin
          // Bit 1 is kept zero whatever the host sends
          nxt.ctrl2 = {i_wdata[7:2], 1'b0, i_wdata[0]};
          // Self-clearing bits stay one while their action runs
          if (cur.ctrl2[BIT_TRIM_RELOAD]) begin
            nxt.ctrl2[BIT_TRIM_RELOAD] = 1'b1;
          end
          if (cur.ctrl2[BIT_SINGLE_CONV]) begin
            nxt.ctrl2[BIT_SINGLE_CONV] = 1'b1;
          end
          // Single conversion refused outside power-down
          if (i_wdata[BIT_SINGLE_CONV] && !cur.ctrl2[BIT_SINGLE_CONV]) begin
            if (i_rate_field == RATE_POWER_DOWN) begin
              nxt.conv_start = 1'b1;
              nxt.conv_cnt   = 8'(CONV_CYCLES);
            end else begin
              nxt.ctrl2[BIT_SINGLE_CONV] = 1'b0;
            end
          end
        end
        OFF_IRQ_PIN_CONTROL: nxt.irqc = i_wdata;
        OFF_QUEUE_CONFIG:    nxt.qcfg = i_wdata;
        OFF_REF_LOW:         nxt.refp[7:0]   = i_wdata;
        OFF_REF_MID:         nxt.refp[15:8]  = i_wdata;
        OFF_REF_HIGH:        nxt.refp[23:16] = i_wdata;
        OFF_OFFSET_LOW:      nxt.offs[7:0]   = i_wdata;
        OFF_OFFSET_HIGH:     nxt.offs[15:8]  = i_wdata;
        // Only bit 0 is kept; upper bits are the host's to zero
        OFF_LOW_CURRENT:     nxt.lc = i_wdata[0];
        default: ;
      endcase
    end
    // Register reads; unmapped addresses read zero
    if (i_rd) begin
      unique case (a)
        OFF_CONTROL_TWO:     nxt.rdata = cur.ctrl2;
        OFF_IRQ_PIN_CONTROL: nxt.rdata = cur.irqc;
        OFF_QUEUE_CONFIG:    nxt.rdata = cur.qcfg;
        OFF_REF_LOW:         nxt.rdata = cur.refp[7:0];
        OFF_REF_MID:         nxt.rdata = cur.refp[15:8];
        OFF_REF_HIGH:        nxt.rdata = cur.refp[23:16];
        OFF_OFFSET_LOW:      nxt.rdata = cur.offs[7:0];
        OFF_OFFSET_HIGH:     nxt.rdata = cur.offs[15:8];
        OFF_LOW_CURRENT:     nxt.rdata = {7'h00, cur.lc};
        default:             nxt.rdata = RST_ZERO;
      endcase
    end
    // Single conversion timer; bit clears when measurement is done
    if (cur.conv_cnt != 8'h00) begin
      nxt.conv_cnt = cur.conv_cnt - 8'h01;
      if (cur.conv_cnt == 8'h01) begin
        nxt.ctrl2[BIT_SINGLE_CONV] = 1'b0;
      end
    end
    // Trim copy: a reload waits one rate tick, then walks every word; the power-up copy starts walking at once
    unique case (cur.trim)
      TR_IDLE: begin
        if (nxt.ctrl2[BIT_TRIM_RELOAD]) begin
          nxt.trim = TR_WAIT;
        end
      end
      TR_WAIT: begin
        nxt.ctrl2[BIT_TRIM_RELOAD] = 1'b1;
        if (i_rate_tick) begin
          nxt.trim     = TR_COPY;
          nxt.trim_cnt = 8'h00;
        end
      end
      TR_COPY: begin
        nxt.ctrl2[BIT_TRIM_RELOAD] = 1'b1;
        nxt.trim_we  = 1'b1;
        // Index travels with its strobe, so the load lands on the right word
        nxt.trim_addr = cur.trim_cnt;
        nxt.trim_cnt = cur.trim_cnt + 8'h01;
        if (cur.trim_cnt == 8'(TRIM_WORDS - 1)) begin
          nxt.trim = TR_IDLE;
          nxt.ctrl2[BIT_TRIM_RELOAD] = 1'b0;
        end
      end
      default: nxt.trim = TR_IDLE;
    endcase
    // Soft reset: restores the listed registers in one cycle, bit reads back zero
    if (i_wr && a == OFF_CONTROL_TWO && i_wdata[BIT_SOFT_RESET]) begin
      nxt.ctrl2      = RST_CONTROL_TWO;
      nxt.irqc       = RST_ZERO;
      nxt.qcfg       = RST_ZERO;
      nxt.refp       = 24'h000000;
      nxt.rate_reset = 1'b1;
      nxt.conv_cnt   = 8'h00;
      nxt.conv_start = 1'b0;
      // A running trim copy is not cut short
      if (cur.trim != TR_IDLE) begin
        nxt.ctrl2[BIT_TRIM_RELOAD] = 1'b1;
      end
    end
    // Interrupt pin: data signal is the OR of every enabled route, with no priority
    // Pin follows the settings being stored, so drive mode and level never disagree
    data_sig = (nxt.irqc[2] & i_data_ready) | (nxt.irqc[4] & i_queue_watermark) |
               (nxt.irqc[3] & i_queue_overrun) | (nxt.irqc[5] & i_queue_full);
    unique case (nxt.irqc[1:0])
      SRC_DATA:     raw_irq = data_sig;
      SRC_HIGH:     raw_irq = i_pressure_high;
      SRC_LOW:      raw_irq = i_pressure_low;
      SRC_LOW_HIGH: raw_irq = i_pressure_low | i_pressure_high;
    endcase
    nxt.int_out = raw_irq ^ nxt.irqc[7];
    // Open drain drives only the low level
    nxt.int_oe  = nxt.irqc[6] ? ~nxt.int_out : 1'b1;
  end

  // ----------------------------------------
  // Registers; power-up starts a trim copy
  // ----------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      cur          <= '0;
      cur.trim     <= TR_COPY;
      cur.ctrl2    <= RST_CONTROL_TWO;
      cur.int_oe   <= 1'b1;
    end else begin
      cur <= nxt;
    end
  end

  // ----------------------------------------
  // Outputs straight from flip-flops
  // ----------------------------------------
  assign O_RDATA            = cur.rdata;
  assign O_TRIM_ADDR        = cur.trim_addr;
  assign O_TRIM_WE          = cur.trim_we;
  assign O_CONV_START       = cur.conv_start;
  assign O_RATE_RESET       = cur.rate_reset;
  assign O_QUEUE_ENABLE     = cur.ctrl2[BIT_QUEUE_EN];
  assign O_WATERMARK_STOP   = cur.ctrl2[BIT_WM_STOP];
  assign O_TWO_WIRE_DISABLE = cur.ctrl2[BIT_TWO_WIRE_DIS];
  assign O_QUEUE_MODE       = cur.qcfg[7:5];
  assign O_WATERMARK_LEVEL  = cur.qcfg[4:0];
  assign O_REFERENCE        = cur.refp;
  assign O_OFFSET           = cur.offs;
  assign O_LOW_CURRENT      = cur.lc;
  assign O_INT_OUT          = cur.int_out;
  assign O_INT_OE           = cur.int_oe;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_reload_clears;
    @(posedge I_CLOCK) disable iff (I_RST)
      (cur.trim == TR_COPY && cur.trim_cnt == 8'(TRIM_WORDS - 1)) |=> !cur.ctrl2[BIT_TRIM_RELOAD];
  endproperty
  a_reload_clears: assert property (p_reload_clears) else $error("trim reload not cleared");

  property p_reload_waits;
    @(posedge I_CLOCK) disable iff (I_RST)
      (cur.trim == TR_WAIT && !i_rate_tick) |=> !cur.trim_we;
  endproperty
  a_reload_waits: assert property (p_reload_waits) else $error("trim copy before rate tick");

  property p_soft_reset;
    @(posedge I_CLOCK) disable iff (I_RST)
      (i_wr && a == OFF_CONTROL_TWO && i_wdata[BIT_SOFT_RESET]) |=>
        (cur.irqc == RST_ZERO && cur.refp == 24'h000000 && !cur.ctrl2[BIT_SOFT_RESET]);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

  property p_single_refused;
    @(posedge I_CLOCK) disable iff (I_RST)
      (i_rate_field != RATE_POWER_DOWN) |=> !cur.conv_start;
  endproperty
  a_single_refused: assert property (p_single_refused) else $error("conversion outside power-down");

  property p_single_clears;
    @(posedge I_CLOCK) disable iff (I_RST)
      $rose(cur.conv_start) |-> cur.ctrl2[BIT_SINGLE_CONV] ##[1:40] !cur.ctrl2[BIT_SINGLE_CONV];
  endproperty
  a_single_clears: assert property (p_single_clears) else $error("single conversion stuck");

  property p_autoinc;
    @(posedge I_CLOCK) disable iff (I_RST)
      (access && !cur.ctrl2[BIT_AUTOINC]) |=> cur.addr == $past(a);
  endproperty
  a_autoinc: assert property (p_autoinc) else $error("address moved with increment off");

  property p_open_drain;
    @(posedge I_CLOCK) disable iff (I_RST)
      (cur.irqc[6] && cur.int_oe) |-> !cur.int_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

  property p_high_source;
    @(posedge I_CLOCK) disable iff (I_RST)
      (cur.irqc[1:0] == SRC_HIGH && !cur.irqc[7] && $past(i_pressure_high)) |-> cur.int_out;
  endproperty
  a_high_source: assert property (p_high_source) else $error("pressure high not routed");

  property p_bit_one;
    @(posedge I_CLOCK) disable iff (I_RST) !cur.ctrl2[1];
  endproperty
  a_bit_one: assert property (p_bit_one) else $error("reserved bit set");

  property p_copy_addr;
    @(posedge I_CLOCK) disable iff (I_RST)
      (cur.trim == TR_COPY) |=> (cur.trim_we && cur.trim_addr == $past(cur.trim_cnt));
  endproperty
  a_copy_addr: assert property (p_copy_addr) else $error("trim word strobe or index wrong");

  property p_soft_restore;
    @(posedge I_CLOCK) disable iff (I_RST)
      (i_wr && a == OFF_CONTROL_TWO && i_wdata[BIT_SOFT_RESET]) |=>
        (cur.rate_reset && cur.qcfg == RST_ZERO && cur.ctrl2[BIT_AUTOINC] && cur.conv_cnt == 8'h00);
  endproperty
  a_soft_restore: assert property (p_soft_restore) else $error("soft reset left queue or rate state");

  property p_conv_pulse;
    @(posedge I_CLOCK) disable iff (I_RST)
      cur.conv_start |=> !cur.conv_start;
  endproperty
  a_conv_pulse: assert property (p_conv_pulse) else $error("conversion start longer than one cycle");

  property p_lc_write;
    @(posedge I_CLOCK) disable iff (I_RST)
      (i_wr && a == OFF_LOW_CURRENT) |=> cur.lc == $past(i_wdata[0]);
  endproperty
  a_lc_write: assert property (p_lc_write) else $error("low current bit not stored");

  property p_push_pull;
    @(posedge I_CLOCK) disable iff (I_RST)
      !cur.irqc[6] |-> cur.int_oe;
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull pin not driven");

  property p_ref_high;
    @(posedge I_CLOCK) disable iff (I_RST)
      (i_wr && a == OFF_REF_HIGH) |=> cur.refp[23:16] == $past(i_wdata);
  endproperty
  a_ref_high: assert property (p_ref_high) else $error("reference high byte not stored");
endmodule

/* verification/host_port_model.sv */
// Host-side register port model driving the byte-wide access strobes
`timescale 1ns/1ns
module host_port_model
  import sensor_control_pkg::*;
(
  input  wire logic       i_clk,
  output logic            o_wr,
  output logic            o_rd,
  output logic            o_first,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata
);
  // --------------------------------------------------
  // Bus cycles
  // --------------------------------------------------
  // Released strobes drop; address and data lines show the inverse, so stale values never look valid
  task automatic rel();
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_first = 1'b0;
    o_addr  = ~o_addr;
    o_wdata = ~o_wdata;
  endtask
  // One byte per call, launched just after an edge, taken at the next
  task automatic put(input logic w, input logic f, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_wr    = w;
    o_rd    = ~w;
    o_first = f;
    o_addr  = a;
    o_wdata = d;
    if (w && f && a == OFF_CONTROL_TWO) o_wdata[1] = 1'b0;
    if (w && f && a == OFF_LOW_CURRENT) o_wdata[7:2] = 6'h00;
  endtask
  // Ends a burst; strobes drop one edge later
  task automatic idle();
    @(posedge i_clk);
    #1;
    rel();
  endtask
  initial begin
    o_addr  = 8'h00;
    o_wdata = 8'h00;
    rel();
  end
endmodule

/* verification/sensor_control_register_bank_test.sv */
// Self-checking bench for the sensor control register bank
`timescale 1ns/1ns
module sensor_control_register_bank_test;
  import sensor_control_pkg::*;
  // --------------------------------------------------
  // Signals
  // --------------------------------------------------
  localparam int TW = 4;                 // Short trim copy keeps the run brief
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr, rd, first, tick, ph, pl, twe, conv, rrst, qen, wstop, twd, lc, iout, ioe;
  logic [7:0]  addr, wdata, rdata, taddr, d[5], e[10];
  logic [2:0]  rate, qmode;
  logic [3:0]  ev;                       // Full, watermark, overrun, data ready
  logic [4:0]  wlev;
  logic [23:0] ref_v;
  logic [15:0] off_v, lf = 16'h0001;
  logic        rd_q = 1'b0;              // Read taken at last edge
  logic [7:0]  exp_q[$];                 // Expected read bytes, oldest first
  int          err_total = 0, n_tests = 0, we_cnt = 0, conv_cnt = 0, rr_cnt = 0;
  always #5 clk = ~clk;
  host_port_model u_host (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_first(first), .o_addr(addr), .o_wdata(wdata));
  sensor_control_register_bank #(.TRIM_WORDS(TW)) u_dut (
    .I_CLOCK(clk), .I_RST(rst), .i_wr(wr), .i_rd(rd), .i_first(first), .i_addr(addr), .i_wdata(wdata),
    .i_rate_field(rate), .i_rate_tick(tick), .i_trim_data(lf[7:0]), .i_queue_full(ev[3]),
    .i_queue_watermark(ev[2]), .i_queue_overrun(ev[1]), .i_data_ready(ev[0]), .i_pressure_high(ph),
    .i_pressure_low(pl), .O_RDATA(rdata), .O_TRIM_ADDR(taddr), .O_TRIM_WE(twe), .O_CONV_START(conv),
    .O_RATE_RESET(rrst), .O_QUEUE_ENABLE(qen), .O_WATERMARK_STOP(wstop), .O_QUEUE_MODE(qmode),
    .O_WATERMARK_LEVEL(wlev), .O_TWO_WIRE_DISABLE(twd), .O_REFERENCE(ref_v), .O_OFFSET(off_v),
    .O_LOW_CURRENT(lc), .O_INT_OUT(iout), .O_INT_OE(ioe));
  // --------------------------------------------------
  // Helpers
  // --------------------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic chk_rd(input logic [7:0] g, input logic [7:0] x);
    n_tests++;
    if (g !== x) begin
      err_total++;
      $display("ERROR t=%0t read got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic rdx(input logic f, input logic [7:0] a, input logic [7:0] x);
    u_host.put(1'b0, f, a, 8'h00);
    exp_q.push_back(x);
  endtask
  task automatic wr1(input logic [7:0] a, input logic [7:0] v);
    u_host.put(1'b1, 1'b1, a, v);
    u_host.idle();
  endtask
  // Ten-byte burst from control_two, pointer stepping past the gap
  task automatic burst();
    rdx(1'b1, OFF_CONTROL_TWO, e[0]);
    for (int i = 1; i < 10; i++) rdx(1'b0, 8'h00, e[i]);
    u_host.idle();
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // --------------------------------------------------
  // Monitor: strobes counted and read bytes compared mid-cycle
  // --------------------------------------------------
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) begin
    if (twe === 1'b1) begin
      chk(taddr, we_cnt);
      we_cnt++;
    end
    if (conv === 1'b1) conv_cnt++;
    if (rrst === 1'b1) rr_cnt++;
    if (rd_q === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h0, 32'hFF);
      else chk_rd(rdata, exp_q.pop_front());
    end
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial begin
    rate = 3'h0;
    tick = 1'b0;
    ev = 4'h0;
    ph = 1'b0;
    pl = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    rdx(1'b1, OFF_CONTROL_TWO, 8'h90);
    u_host.idle();
    repeat (8) @(posedge clk);
    chk(we_cnt, TW);
    e = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    burst();
    // Random reference and offset bytes in one auto-incremented burst
    for (int i = 0; i < 5; i++) begin
      lf = nxt(lf);
      d[i] = lf[7:0];
    end
    u_host.put(1'b1, 1'b1, OFF_REF_LOW, d[0]);
    for (int i = 1; i < 5; i++) u_host.put(1'b1, 1'b0, 8'h00, d[i]);
    u_host.idle();
    chk(ref_v, {d[2], d[1], d[0]});
    chk(off_v, {d[4], d[3]});
    // Fixed address: second byte overwrites queue_config, every mode code
    wr1(OFF_CONTROL_TWO, 8'h68);
    chk({qen, wstop, twd}, 3'b111);
    for (int m = 0; m < 8; m++) begin
      u_host.put(1'b1, 1'b1, OFF_QUEUE_CONFIG, {m[2:0], 5'h1F});
      u_host.put(1'b1, 1'b0, 8'h00, {m[2:0], 5'h0A});
      u_host.idle();
      chk({qmode, wlev}, {m[2:0], 5'h0A});
    end
    chk(ref_v[7:0], d[0]);
    // Each route enable against its own event, then the next route enabled instead
    for (int k = 0; k < 4; k++) begin
      ev = 4'h1 << k;
      wr1(OFF_IRQ_PIN_CONTROL, {2'b00, 4'h1 << k, 2'b00});
      settle();
      chk(iout, 1'b1);
      wr1(OFF_IRQ_PIN_CONTROL, {2'b00, 4'h1 << ((k + 1) % 4), 2'b00});
      settle();
      chk(iout, 1'b0);
    end
    // Source codes with data ready on and one threshold event
    ev = 4'h1;
    for (int j = 0; j < 2; j++) begin
      ph = j[0];
      pl = ~j[0];
      for (int c = 0; c < 4; c++) begin
        wr1(OFF_IRQ_PIN_CONTROL, {6'h01, c[1:0]});
        settle();
        chk(iout, (c == 0) | (c[0] & ph) | (c[1] & pl));
      end
    end
    wr1(OFF_IRQ_PIN_CONTROL, 8'h84);
    settle();
    chk({iout, ioe}, 2'b01);
    wr1(OFF_IRQ_PIN_CONTROL, 8'hC4);
    ev = 4'h0;
    settle();
    chk({iout, ioe}, 2'b10);
    // Single conversion refused outside power-down, then accepted
    rate = 3'h1;
    conv_cnt = 0;
    wr1(OFF_CONTROL_TWO, 8'h11);
    rdx(1'b1, OFF_CONTROL_TWO, 8'h10);
    u_host.idle();
    rate = RATE_POWER_DOWN;
    wr1(OFF_CONTROL_TWO, 8'h11);
    rdx(1'b1, OFF_CONTROL_TWO, 8'h11);
    u_host.idle();
    repeat (CONV_CYCLES + 8) @(posedge clk);
    rdx(1'b1, OFF_CONTROL_TWO, 8'h10);
    u_host.idle();
    chk(conv_cnt, 1);
    wr1(OFF_LOW_CURRENT, 8'hFD);
    settle();
    chk(lc, 1'b1);
    // Soft reset wins over other bits, offset survives
    rr_cnt = 0;
    wr1(OFF_QUEUE_CONFIG, 8'hE3);
    wr1(OFF_CONTROL_TWO, 8'h74);
    settle();
    chk(ref_v, 24'h0);
    chk(rr_cnt, 1);
    e = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, d[3], d[4], 8'h01};
    burst();
    // Trim reload waits for a rate tick
    we_cnt = 0;
    wr1(OFF_CONTROL_TWO, 8'h90);
    repeat (4) @(posedge clk);
    chk(we_cnt, 0);
    rdx(1'b1, OFF_CONTROL_TWO, 8'h90);
    u_host.idle();
    tick = 1'b1;
    @(posedge clk);
    #1 tick = 1'b0;
    repeat (TW + 6) @(posedge clk);
    chk(we_cnt, TW);
    rdx(1'b1, OFF_CONTROL_TWO, 8'h10);
    u_host.idle();
    repeat (3) @(posedge clk);
    chk(exp_q.size(), 0);
    end_of_test();
  end
endmodule
